// File: inc/wsi_pkg.sv
// types shared by the wake/status block
package wsi_pkg;

    // ****************************************
    // status register layout
    // ****************************************
    typedef struct packed {
        logic [4:0] key;  // key_status_bit 5..1
        logic wake;       // woken by wake_pin
        logic low;        // external supply low
        logic aux;        // aux supply present
    } wsi_status_t;

    // ****************************************
    // register port request
    // ****************************************
    typedef struct packed {
        logic rd_stb;      // register read strobe
        logic [4:0] addr;  // register address
        logic cmd_stb;     // command strobe
        logic [2:0] cmd;   // command bits 7..5
    } wsi_req_t;

    typedef enum logic {
        WSI_DB_IDLE,
        WSI_DB_RUN
    } wsi_db_state_t;

endpackage

// File: inc/wsi_regs.svh
// offsets, field positions, reset values and counts of the wake/status block
`ifndef WSI_REGS_SVH
`define WSI_REGS_SVH

// ****************************************
// register map and commands
// ****************************************
`define WSI_STATUS_ADR 5'h08
`define WSI_CMD_IRQ_CLR 3'h5
`define WSI_STATUS_RST 8'h00

// ****************************************
// status field positions
// ****************************************
`define WSI_POS_AUX 0
`define WSI_POS_LOW 1
`define WSI_POS_WAKE 2
`define WSI_POS_KEY 3

// ****************************************
// timing counts
// ****************************************
// debounce terminal count in divided data clock periods
`define WSI_DEB_TERM 8195
// core clock cycles per divided data clock period
`define WSI_DIVIDED_DATA_CLOCK_DIV 16
// least hold time of a wake level in off mode, in ns
`define WSI_WAKE_MIN_NS 1000
`define WSI_CLK_NS 10
`define WSI_WAKE_MIN_CYC \
    ((`WSI_WAKE_MIN_NS + `WSI_CLK_NS - 1) / `WSI_CLK_NS)

`endif

// File: logic/wsi_wakeup_irq.sv
// wake-up sources, status flags and interrupt line of the transceiver
// Function
// R01 - status register readable at address 8
// R02 - interrupt on wake, aux, or key events
// R03 - status read clears sticky flags and interrupt
// R04 - key bits report inverted key level
// R05 - wake flag forces supply and clock enables
// R06 - low flag clears on recovery plus read
// R07 - off mode key fall wakes device
// R08 - after key wake set key bit, interrupt
// R09 - first host clock cycle may be short
// R10 - key event clears and starts debounce counter
// R11 - terminal count updates keys, interrupts, stops
// R12 - same key again stops counter, no update
// R13 - other key event restarts the counter
// R14 - running counter forces supply and clock enables
// R15 - key interrupt cleared by read or command
// R16 - off mode wake pin rise wakes device
// R17 - wake rise sets flag, irq on 0-to-1
// R18 - low wake pin never enters off mode
// R19 - aux detect sets aux flag and interrupt
// R20 - aux rise sets flag, irq on 0-to-1
// R21 - clear command 101 drops interrupt
// R22 - interrupt level holds until cleared
`timescale 1ns/100ps

`include "wsi_regs.svh"

module wsi_wakeup_irq
    import wsi_pkg::*;
#(
    parameter int DEB_TERM = `WSI_DEB_TERM,
    parameter int DIVIDED_DATA_CLOCK_DIV = `WSI_DIVIDED_DATA_CLOCK_DIV,
    parameter int WAKE_MIN = `WSI_WAKE_MIN_CYC
) (
    input wire logic core_clk,          // 100 MHz clock
    input wire logic rst_b,             // async reset, low
    input wire logic off_mode,          // power mode is off
    input wire logic [4:0] key_input,   // key pins, low active
    input wire logic wake_pin,          // wake pin level
    input wire logic aux_supply_pin,    // aux above threshold
    input wire logic supply_low,        // supply out below low
    input wire logic supply_good,       // supply above upper
    input wire logic ctrl3_sup_en,      // control reg 3 supply bit
    input wire logic ctrl3_clk_en,      // control reg 3 clock bit
    input wsi_req_t req,                // register/command port
    output logic [7:0] rd_data_reg,     // read data
    output logic irq_reg,               // interrupt to host
    output logic host_reset_b_reg,      // host reset, low
    output logic supplies_on_reg,       // internal/ext supplies
    output logic supply_out_enable_reg, // effective supply bit
    output logic clk_out_enable_reg     // effective clock bit
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // one-hot to index; events on several keys take the lowest
    function automatic logic [2:0] first_set(input logic [4:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    logic [4:0] key_bits_reg;
    logic wake_flag_reg;
    logic low_flag_reg;
    logic aux_flag_reg;
    wsi_status_t status;
    wsi_db_state_t db_state_reg;
    logic [4:0] key_prev_reg;
    logic wake_prev_reg;
    logic aux_prev_reg;
    logic off_prev_reg;
    logic [15:0] divided_data_clock_cnt_reg;
    logic [13:0] deb_cnt_reg;
    logic [2:0] deb_key_reg;
    logic [15:0] hold_cnt_reg;
    logic key_woke_reg;
    logic pin_woke_reg;
    logic low_read_reg;

    logic divided_data_clock_tick;
    logic active;
    logic stat_rd;
    logic irq_clr;
    logic [4:0] key_evt;
    logic any_key_evt;
    logic deb_done;
    logic resume;
    logic wake_set;
    logic aux_set;
    logic key_irq;

    assign active = ~off_mode;
    assign stat_rd = req.rd_stb && (req.addr == `WSI_STATUS_ADR); // R01
    assign irq_clr = req.cmd_stb && (req.cmd == `WSI_CMD_IRQ_CLR); // R21
    assign key_evt = active ? (key_input ^ key_prev_reg) : 5'h00;
    assign any_key_evt = |key_evt;
    assign resume = off_prev_reg & active;
    assign status = '{key: key_bits_reg, wake: wake_flag_reg,
        low: low_flag_reg, aux: aux_flag_reg};

    // ****************************************
    // divided data clock
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            divided_data_clock_cnt_reg <= 16'h0000;
        end else if (divided_data_clock_cnt_reg == 16'(DIVIDED_DATA_CLOCK_DIV - 1)) begin
            divided_data_clock_cnt_reg <= 16'h0000;
        end else begin
            divided_data_clock_cnt_reg <= divided_data_clock_cnt_reg + 16'h0001;
        end
    end

    assign divided_data_clock_tick = (divided_data_clock_cnt_reg == 16'(DIVIDED_DATA_CLOCK_DIV - 1));

    // ****************************************
    // edge history
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            key_prev_reg <= 5'h1F;
            wake_prev_reg <= 1'b0;
            aux_prev_reg <= 1'b0;
            off_prev_reg <= 1'b0;
        end else begin
            key_prev_reg <= key_input;
            wake_prev_reg <= wake_pin;
            aux_prev_reg <= aux_supply_pin;
            off_prev_reg <= off_mode;
        end
    end

    // ****************************************
    // debounce counter
    // ****************************************
    assign deb_done = (db_state_reg == WSI_DB_RUN) && divided_data_clock_tick
        && (deb_cnt_reg == 14'(DEB_TERM - 1)); // R11

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            db_state_reg <= WSI_DB_IDLE;
            deb_cnt_reg <= 14'h0000;
            deb_key_reg <= 3'h0;
        end else begin
            case (db_state_reg)
                WSI_DB_IDLE: begin
                    if (any_key_evt) begin
                        db_state_reg <= WSI_DB_RUN; // R10
                        deb_cnt_reg <= 14'h0000;
                        deb_key_reg <= first_set(key_evt);
                    end
                end
                WSI_DB_RUN: begin
                    if (any_key_evt && key_evt[deb_key_reg]) begin
                        db_state_reg <= WSI_DB_IDLE; // R12
                    end else if (any_key_evt) begin
                        deb_cnt_reg <= 14'h0000; // R13
                        deb_key_reg <= first_set(key_evt);
                    end else if (deb_done || off_mode) begin
                        db_state_reg <= WSI_DB_IDLE; // R11
                    end else if (divided_data_clock_tick) begin
                        deb_cnt_reg <= deb_cnt_reg + 14'h0001;
                    end
                end
                default: begin
                    db_state_reg <= WSI_DB_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // off mode wake detection
    // ****************************************
    // hold counter restarts whenever neither wake level is present
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt_reg <= 16'h0000;
            key_woke_reg <= 1'b0;
            pin_woke_reg <= 1'b0;
        end else if (!off_mode) begin
            hold_cnt_reg <= 16'h0000;
            if (off_prev_reg == 1'b0) begin
                key_woke_reg <= 1'b0;
                pin_woke_reg <= 1'b0;
            end
        end else if ((&key_input) && !wake_pin) begin
            hold_cnt_reg <= 16'h0000;
        end else if (hold_cnt_reg == 16'(WAKE_MIN - 1)) begin
            key_woke_reg <= key_woke_reg | ~(&key_input); // R07
            pin_woke_reg <= pin_woke_reg | wake_pin; // R16
        end else begin
            hold_cnt_reg <= hold_cnt_reg + 16'h0001;
        end
    end

    // supplies drop only by the external off request, never by wake_pin
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            supplies_on_reg <= 1'b0;
            host_reset_b_reg <= 1'b0;
        end else begin
            if ((off_mode && hold_cnt_reg == 16'(WAKE_MIN - 1)
                    && !((&key_input) && !wake_pin))
                    || (off_mode && aux_supply_pin)) begin
                supplies_on_reg <= 1'b1; // R07 R16 R19
                host_reset_b_reg <= 1'b0;
            end else if (off_mode && !supplies_on_reg) begin
                host_reset_b_reg <= 1'b0; // R18
            end else if (off_mode && !off_prev_reg) begin
                supplies_on_reg <= 1'b0;
                host_reset_b_reg <= 1'b0;
            end else if (supplies_on_reg || active) begin
                supplies_on_reg <= 1'b1;
                host_reset_b_reg <= supply_good;
            end
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    assign wake_set = (active && rise(wake_pin, wake_prev_reg))
        || (resume && pin_woke_reg); // R17
    assign aux_set = rise(aux_supply_pin, aux_prev_reg); // R19 R20

    // key bits take the inverted pin level at debounce end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            key_bits_reg <= 5'h00;
        end else if (deb_done || (resume && key_woke_reg)) begin
            key_bits_reg <= ~key_input; // R04 R08 R11
        end
    end

    // set beats a same-cycle read clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_flag_reg <= 1'b0;
            aux_flag_reg <= 1'b0;
        end else begin
            if (wake_set) begin
                wake_flag_reg <= 1'b1; // R17
            end else if (stat_rd) begin
                wake_flag_reg <= 1'b0; // R03
            end
            if (aux_set) begin
                aux_flag_reg <= 1'b1; // R20
            end else if (stat_rd) begin
                aux_flag_reg <= 1'b0; // R03
            end
        end
    end

    // read may come after supply_low ends but before recovery; remember it until then
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_flag_reg <= 1'b0;
            low_read_reg <= 1'b0;
        end else if (supply_low) begin
            low_flag_reg <= 1'b1;
            low_read_reg <= 1'b0;
        end else if (low_flag_reg && supply_good
                && (stat_rd || low_read_reg)) begin
            low_flag_reg <= 1'b0; // R06
            low_read_reg <= 1'b0;
        end else if (stat_rd && low_flag_reg) begin
            low_read_reg <= 1'b1; // R03
        end
    end

    // ****************************************
    // interrupt
    // ****************************************
    assign key_irq = deb_done || (resume && key_woke_reg); // R08 R11

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else if (key_irq || (wake_set && !wake_flag_reg)
                || (aux_set && !aux_flag_reg)) begin
            irq_reg <= 1'b1; // R02 R17 R20 R22
        end else if (stat_rd || irq_clr) begin
            irq_reg <= 1'b0; // R03 R15 R21
        end
    end

    // ****************************************
    // read data and forced enables
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_reg <= `WSI_STATUS_RST;
        end else if (stat_rd) begin
            rd_data_reg <= status; // R01
        end
    end

    // clock gate downstream is asynchronous: host sees a short first cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            supply_out_enable_reg <= 1'b0;
            clk_out_enable_reg <= 1'b0;
        end else begin
            supply_out_enable_reg <= ctrl3_sup_en || wake_flag_reg
                || (db_state_reg == WSI_DB_RUN); // R05 R14
            clk_out_enable_reg <= ctrl3_clk_en || wake_flag_reg
                || (db_state_reg == WSI_DB_RUN); // R05 R09 R14
        end
    end

endmodule

// File: testbench/tb_top.sv
// self-checking bench of the wake/status block
`timescale 1ns/100ps
`include "wsi_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module tb_top;
    import wsi_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic off_mode = 1'b0;
    logic [4:0] key_input = 5'h1F;
    logic wake_pin = 1'b0;
    logic aux_supply_pin = 1'b0;
    logic supply_low = 1'b0;
    logic supply_good = 1'b1;
    logic ctrl3_sup_en = 1'b0;
    logic ctrl3_clk_en = 1'b0;
    wsi_req_t req;
    logic [7:0] rd_data_reg;
    logic irq_reg, host_reset_b_reg, supplies_on_reg;
    logic supply_out_enable_reg, clk_out_enable_reg, s;
    logic [7:0] d;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 core_clk = ~core_clk;
    // short counts keep the run brief
    wsi_wakeup_irq #(.DEB_TERM(4), .DIVIDED_DATA_CLOCK_DIV(2), .WAKE_MIN(3))
    u_wsi_wakeup_irq (.core_clk(core_clk), .rst_b(rst_b),
        .off_mode(off_mode), .key_input(key_input), .wake_pin(wake_pin),
        .aux_supply_pin(aux_supply_pin), .supply_low(supply_low),
        .supply_good(supply_good), .ctrl3_sup_en(ctrl3_sup_en),
        .ctrl3_clk_en(ctrl3_clk_en), .req(req), .rd_data_reg(rd_data_reg),
        .irq_reg(irq_reg), .host_reset_b_reg(host_reset_b_reg),
        .supplies_on_reg(supplies_on_reg),
        .supply_out_enable_reg(supply_out_enable_reg),
        .clk_out_enable_reg(clk_out_enable_reg));
    wsi_host_model u_wsi_host_model (.core_clk(core_clk),
        .rd_data_reg(rd_data_reg), .req(req));
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // irq is a level, so any high sample in the window counts
    task automatic irq_in(input int n, output logic seen);
        seen = 1'b0;
        repeat (n) begin
            @(posedge core_clk);
            #1 seen = seen | irq_reg;
        end
    endtask
    task automatic rd_chk(input logic [7:0] exp);
        u_wsi_host_model.rd(`WSI_STATUS_ADR, d);
        `CHK(d, exp)
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        tick(2);
        `CHK(rd_data_reg, `WSI_STATUS_RST)
        rd_chk(8'h00);
        @(posedge core_clk) wake_pin <= 1'b1;
        irq_in(10, s);
        `CHK(s, 1'b1)
        `CHK(supply_out_enable_reg & clk_out_enable_reg, 1'b1)
        rd_chk(8'h04);
        `CHK(irq_reg, 1'b0)
        rd_chk(8'h00);
        @(posedge core_clk) wake_pin <= 1'b0;
        tick(2);
        @(posedge core_clk) wake_pin <= 1'b1;
        irq_in(10, s);
        `CHK(s, 1'b1)
        u_wsi_host_model.clr();
        `CHK(irq_reg, 1'b0)
        @(posedge core_clk) wake_pin <= 1'b0;
        tick(2);
        @(posedge core_clk) wake_pin <= 1'b1;
        irq_in(10, s);
        `CHK(s, 1'b0)
        rd_chk(8'h04);
        @(posedge core_clk) aux_supply_pin <= 1'b1;
        irq_in(10, s);
        `CHK(s, 1'b1)
        rd_chk(8'h01);
        @(posedge core_clk) {supply_low, supply_good} <= 2'b10;
        tick(3);
        @(posedge core_clk) {supply_low, supply_good} <= 2'b01;
        tick(3);
        rd_chk(8'h02);
        rd_chk(8'h00);
        @(posedge core_clk) {supply_low, supply_good} <= 2'b10;
        tick(3);
        rd_chk(8'h02);
        rd_chk(8'h02);
        @(posedge core_clk) {supply_low, supply_good} <= 2'b01;
        tick(3);
        // reads while the supply is still low are not remembered
        rd_chk(8'h02);
        rd_chk(8'h00);
        u_wsi_host_model.rd(5'h03, d);
        `CHK(rd_data_reg, 8'h00)
        @(posedge core_clk) {ctrl3_sup_en, ctrl3_clk_en} <= 2'b11;
        tick(3);
        `CHK(supply_out_enable_reg & clk_out_enable_reg, 1'b1)
        @(posedge core_clk) {ctrl3_sup_en, ctrl3_clk_en} <= 2'b00;
        tick(3);
        `CHK(supply_out_enable_reg | clk_out_enable_reg, 1'b0)
        @(posedge core_clk) key_input <= 5'h1B;
        tick(3);
        `CHK(supply_out_enable_reg & clk_out_enable_reg, 1'b1)
        irq_in(40, s);
        `CHK(s, 1'b1)
        rd_chk(8'h20);
        @(posedge core_clk) key_input <= 5'h1A;
        @(posedge core_clk) key_input <= 5'h1B;
        irq_in(40, s);
        `CHK(s, 1'b0)
        rd_chk(8'h20);
        @(posedge core_clk) key_input <= 5'h1A;
        tick(3);
        @(posedge core_clk) key_input <= 5'h18;
        irq_in(40, s);
        `CHK(s, 1'b1)
        rd_chk(8'h38);
        @(posedge core_clk) key_input <= 5'h1F;
        irq_in(40, s);
        u_wsi_host_model.clr();
        `CHK(irq_reg, 1'b0)
        rd_chk(8'h00);
        // aux and wake must be low or they would wake the device at once
        @(posedge core_clk) {off_mode, supply_good, wake_pin,
            aux_supply_pin} <= 4'b1000;
        tick(3);
        `CHK(supplies_on_reg, 1'b0)
        @(posedge core_clk) key_input <= 5'h0F;
        tick(6);
        `CHK({supplies_on_reg, host_reset_b_reg}, 2'b10)
        @(posedge core_clk) {off_mode, supply_good} <= 2'b01;
        irq_in(10, s);
        `CHK(s & host_reset_b_reg, 1'b1)
        rd_chk(8'h80);
        @(posedge core_clk) key_input <= 5'h1F;
        irq_in(40, s);
        rd_chk(8'h00);
        @(posedge core_clk) {off_mode, supply_good} <= 2'b10;
        tick(3);
        @(posedge core_clk) wake_pin <= 1'b1;
        tick(6);
        `CHK({supplies_on_reg, host_reset_b_reg}, 2'b10)
        @(posedge core_clk) {off_mode, supply_good} <= 2'b01;
        irq_in(10, s);
        `CHK(s, 1'b1)
        rd_chk(8'h04);
        @(posedge core_clk) wake_pin <= 1'b0;
        tick(20);
        `CHK(supplies_on_reg, 1'b1)
        end_of_test();
    end
endmodule

// File: testbench/wsi_host_model.sv
// host model issuing register reads and the interrupt clear command
`timescale 1ns/100ps
`include "wsi_regs.svh"
module wsi_host_model
    import wsi_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic [7:0] rd_data_reg, // read data
    output wsi_req_t req // requests
);
    initial req = '0;
    // request held for one taking edge, data taken one edge later
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk) req <= '{1'b1, a, 1'b0, 3'h0};
        @(posedge core_clk) req <= '0;
        @(posedge core_clk) #1 d = rd_data_reg;
    endtask
    task automatic clr();
        @(posedge core_clk) req <= '{1'b0, 5'h00, 1'b1, `WSI_CMD_IRQ_CLR};
        @(posedge core_clk) req <= '0;
        @(posedge core_clk) #1;
    endtask
endmodule

// File: testbench/wsi_irq_monitor.sv
// port checks of the wake/status block
`timescale 1ns/100ps
`include "wsi_regs.svh"
module wsi_irq_monitor
    import wsi_pkg::*;
#(
    parameter int DEB_TERM = `WSI_DEB_TERM,
    parameter int DIVIDED_DATA_CLOCK_DIV = `WSI_DIVIDED_DATA_CLOCK_DIV,
    parameter int WAKE_MIN = `WSI_WAKE_MIN_CYC
) (
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, low
    input wire logic off_mode, // off mode
    input wire logic [4:0] key_input, // keys
    input wire logic wake_pin, // wake pin
    input wire logic aux_supply_pin, // aux detect
    input wire logic supply_low, // low supply
    input wire logic supply_good, // supply ok
    input wire logic ctrl3_sup_en, // sw bit
    input wire logic ctrl3_clk_en, // sw bit
    input wsi_req_t req, // requests
    input wire logic [7:0] rd_data_reg, // read data
    input wire logic irq_reg, // interrupt
    input wire logic host_reset_b_reg, // host reset
    input wire logic supplies_on_reg, // supplies
    input wire logic supply_out_enable_reg, // supply en
    input wire logic clk_out_enable_reg // clock en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic rd8, clr, calm;
    logic [7:0] in_q;
    // a new cause in the clearing cycle wins, so only quiet inputs count
    always_ff @(posedge core_clk) in_q <= {off_mode, wake_pin,
        aux_supply_pin, key_input};
    assign calm = in_q == {off_mode, wake_pin, aux_supply_pin, key_input};
    assign rd8 = req.rd_stb && req.addr == `WSI_STATUS_ADR;
    assign clr = req.cmd_stb && req.cmd == `WSI_CMD_IRQ_CLR;
    // longer than any debounce run, so the counter is surely idle
    localparam int QUIET = (DEB_TERM + 2) * DIVIDED_DATA_CLOCK_DIV;
    int quiet;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            quiet <= 0;
        end else if (key_input != in_q[4:0]) begin
            quiet <= 0;
        end else if (quiet < QUIET) begin
            quiet <= quiet + 1;
        end
    end
    // a debounce end may also set irq then; the forced clock enable shows it
    property p_rd_drop; rd8 && calm && !clk_out_enable_reg |=> !irq_reg;
    endproperty
    a_rd_drop: assert property (p_rd_drop) else $error("read kept irq");
    property p_clr_drop; clr && calm && !clk_out_enable_reg |=> !irq_reg;
    endproperty
    a_clr_drop: assert property (p_clr_drop) else $error("clear kept irq");
    property p_other_rd; req.rd_stb && !rd8 |=> $stable(rd_data_reg);
    endproperty
    a_other_rd: assert property (p_other_rd) else $error("data changed");
    property p_hold; irq_reg && !rd8 && !clr |=> irq_reg; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped alone");
    property p_wake_en; $rose(wake_pin) && !off_mode |->
        ##[1:3] supply_out_enable_reg && clk_out_enable_reg; endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake enables");
    property p_deb_en;
        (!off_mode && $changed(key_input) && quiet == QUIET) ##1
        $stable(key_input) |=> supply_out_enable_reg && clk_out_enable_reg;
    endproperty
    a_deb_en: assert property (p_deb_en) else $error("count enables");
    property p_keep_on; supplies_on_reg && !off_mode |=> supplies_on_reg;
    endproperty
    a_keep_on: assert property (p_keep_on) else $error("supplies off");
    property p_wake_rst; off_mode && $rose(supplies_on_reg) |->
        !host_reset_b_reg; endproperty
    a_wake_rst: assert property (p_wake_rst) else $error("host reset");
    c_rd: cover property (rd8 ##1 !irq_reg);
    c_irq: cover property ($rose(irq_reg));
    c_wake: cover property (off_mode && $rose(supplies_on_reg));
endmodule
bind wsi_wakeup_irq wsi_irq_monitor #(.DEB_TERM(DEB_TERM),
    .DIVIDED_DATA_CLOCK_DIV(DIVIDED_DATA_CLOCK_DIV), .WAKE_MIN(WAKE_MIN)) u_wsi_irq_monitor (
    .core_clk(core_clk), .rst_b(rst_b), .off_mode(off_mode),
    .key_input(key_input), .wake_pin(wake_pin),
    .aux_supply_pin(aux_supply_pin), .supply_low(supply_low),
    .supply_good(supply_good), .ctrl3_sup_en(ctrl3_sup_en),
    .ctrl3_clk_en(ctrl3_clk_en), .req(req), .rd_data_reg(rd_data_reg),
    .irq_reg(irq_reg), .host_reset_b_reg(host_reset_b_reg),
    .supplies_on_reg(supplies_on_reg),
    .supply_out_enable_reg(supply_out_enable_reg),
    .clk_out_enable_reg(clk_out_enable_reg));
